// File: rtl/port_phy_regs.svh
// Register indices, field positions, reset values and bus codes.
// Behaviour
// - Cable fault count is nine bits read-only; bit 8 in preceding register.
// - One count unit means about 0.4 metres to the cable fault.
// - Negotiation-disable bit set forces speed and duplex from bits 6 and 5.
// - Ports 3 and 4 negotiation-disable resets to inverse of its strap pin.
// - Forced-speed bit selects 100BT when one, 10BT when zero; resets one.
// - Forced duplex applies when negotiation is off or fails; half default.
// - Duplex reset follows LED strap inverted on port 3, carrier strap on 4.
// - Five advertisement bits, one advertises, zero suppresses, all reset one.
// - LED-off bit drives all three port LED pins high.
// - Transmitter-disable bit stops the port transmitter; resets to zero.
// - Writing one to restart bit restarts negotiation and self-clears.
`ifndef PORT_PHY_REGS_SVH
`define PORT_PHY_REGS_SVH

`define CABLE_TEST_P2_IDX 8'h2A
`define CABLE_TEST_P3_IDX 8'h3A
`define CABLE_TEST_P4_IDX 8'h4A
`define CABLE_FAULT_LOW_P2_IDX 8'h2B
`define CABLE_FAULT_LOW_P3_IDX 8'h3B
`define CABLE_FAULT_LOW_P4_IDX 8'h4B
`define NEG_CONTROL_P1_IDX 8'h1C
`define NEG_CONTROL_P2_IDX 8'h2C
`define NEG_CONTROL_P3_IDX 8'h3C
`define NEG_CONTROL_P4_IDX 8'h4C
`define NEG_CONTROL_P5_IDX 8'h5C
`define PORT_MISC_CONTROL_P1_IDX 8'h1D
`define PORT_MISC_CONTROL_P2_IDX 8'h2D
`define PORT_MISC_CONTROL_P3_IDX 8'h3D
`define PORT_MISC_CONTROL_P4_IDX 8'h4D
`define PORT_MISC_CONTROL_P5_IDX 8'h5D

`define NEG_DIS_BIT 7
`define FSPEED_BIT 6
`define FDUPLEX_BIT 5
`define ADV_MSB 4
`define LED_OFF_BIT 7
`define TX_DIS_BIT 6
`define RESTART_BIT 5
`define FAULT_HI_BIT 8

`define NEG_CONTROL_RST 8'h5F
`define LEDS_OFF 3'h7

`define PORT1 3'h0
`define PORT2 3'h1
`define PORT3 3'h2
`define PORT4 3'h3
`define PORT5 3'h4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: rtl/port_phy_pkg.sv
// Types shared by the port register bank.
package port_phy_pkg;
    typedef enum logic [2:0] {
        RK_NONE,
        RK_NEG,
        RK_MISC,
        RK_TEST,
        RK_FAULT
    } reg_kind_e;

    typedef struct packed {
        reg_kind_e kind;
        logic [2:0] port;
    } reg_sel_s;
endpackage

// File: rtl/strap_sync.sv
// Two-stage synchroniser for the four strap pins.
`timescale 1ns/1ps
module strap_sync (
    input wire logic aclk,
    input wire logic [3:0] pin_in,
    output logic [3:0] pin_sync
);
    logic [3:0] stage1_r;

    always_ff @(posedge aclk) begin
        stage1_r <= pin_in;
        pin_sync <= stage1_r;
    end
endmodule

// File: rtl/port_ctrl.sv
// Per-port speed and duplex resolution and LED gating.
`timescale 1ns/1ps
`include "port_phy_regs.svh"
module port_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] neg_ctrl,
    input wire logic led_off,
    input wire logic neg_done,
    input wire logic neg_failed,
    input wire logic res_speed_100,
    input wire logic res_full_duplex,
    input wire logic [2:0] led_normal,
    output logic link_speed_100,
    output logic link_full_duplex,
    output logic [2:0] port_led_pin
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_speed_100 <= 1'b1;
            link_full_duplex <= 1'b0;
        end else if (neg_ctrl[`NEG_DIS_BIT]) begin
            link_speed_100 <= neg_ctrl[`FSPEED_BIT];
            link_full_duplex <= neg_ctrl[`FDUPLEX_BIT];
        end else if (neg_done && !neg_failed) begin
            link_speed_100 <= res_speed_100;
            link_full_duplex <= res_full_duplex;
        end else if (neg_done) begin
            // A failed negotiation keeps the sensed speed.
            link_speed_100 <= res_speed_100;
            link_full_duplex <= neg_ctrl[`FDUPLEX_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_led_pin <= `LEDS_OFF;
        end else if (led_off) begin
            port_led_pin <= `LEDS_OFF;
        end else begin
            port_led_pin <= led_normal;
        end
    end
endmodule

// File: rtl/port_phy_control_regs.sv
// AXI4-Lite register bank for per-port PHY negotiation and control.
`timescale 1ns/1ps
`include "port_phy_regs.svh"
module port_phy_control_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port3_neg_strap_pin,
    input wire logic port4_neg_strap_pin,
    input wire logic port3_duplex_strap_pin,
    input wire logic port4_duplex_strap_pin,
    input wire logic [8:0] fault_count_p2,
    input wire logic [8:0] fault_count_p3,
    input wire logic [8:0] fault_count_p4,
    input wire logic [4:0] neg_done,
    input wire logic [4:0] neg_failed,
    input wire logic [4:0] neg_res_speed_100,
    input wire logic [4:0] neg_res_full_duplex,
    input wire logic [14:0] led_normal,
    output logic [14:0] port_led_pin,
    output logic [4:0] neg_enable,
    output logic [24:0] adv_ability,
    output logic [4:0] tx_disable,
    output logic [4:0] restart_neg,
    output logic [4:0] link_speed_100,
    output logic [4:0] link_full_duplex
);
    logic [7:0] neg_ctrl_r [0:4];
    logic [4:0] led_off_r;
    logic [4:0] tx_dis_r;
    logic [4:0] restart_r;
    logic [3:0] strap_sync_w;
    logic aw_held_r;
    logic [11:0] aw_addr_r;
    logic w_held_r;
    logic [7:0] w_data_r;
    logic w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_fire;
    port_phy_pkg::reg_sel_s wr_sel;
    port_phy_pkg::reg_sel_s rd_sel;
    logic [7:0] rd_byte;

    // Maps a byte address to a register kind and a port (0 = port 1).
    function automatic port_phy_pkg::reg_sel_s decode(input logic [11:0] a);
        port_phy_pkg::reg_sel_s s;
        s.kind = port_phy_pkg::RK_NONE;
        s.port = `PORT1;
        if (a[1:0] == 2'h0 && a[11:10] == 2'h0) begin
            unique case (a[9:2])
                `NEG_CONTROL_P1_IDX: begin
                    s.kind = port_phy_pkg::RK_NEG;
                    s.port = `PORT1;
                end
                `NEG_CONTROL_P2_IDX: begin
                    s.kind = port_phy_pkg::RK_NEG;
                    s.port = `PORT2;
                end
                `NEG_CONTROL_P3_IDX: begin
                    s.kind = port_phy_pkg::RK_NEG;
                    s.port = `PORT3;
                end
                `NEG_CONTROL_P4_IDX: begin
                    s.kind = port_phy_pkg::RK_NEG;
                    s.port = `PORT4;
                end
                `NEG_CONTROL_P5_IDX: begin
                    s.kind = port_phy_pkg::RK_NEG;
                    s.port = `PORT5;
                end
                `PORT_MISC_CONTROL_P1_IDX: begin
                    s.kind = port_phy_pkg::RK_MISC;
                    s.port = `PORT1;
                end
                `PORT_MISC_CONTROL_P2_IDX: begin
                    s.kind = port_phy_pkg::RK_MISC;
                    s.port = `PORT2;
                end
                `PORT_MISC_CONTROL_P3_IDX: begin
                    s.kind = port_phy_pkg::RK_MISC;
                    s.port = `PORT3;
                end
                `PORT_MISC_CONTROL_P4_IDX: begin
                    s.kind = port_phy_pkg::RK_MISC;
                    s.port = `PORT4;
                end
                `PORT_MISC_CONTROL_P5_IDX: begin
                    s.kind = port_phy_pkg::RK_MISC;
                    s.port = `PORT5;
                end
                `CABLE_TEST_P2_IDX: begin
                    s.kind = port_phy_pkg::RK_TEST;
                    s.port = `PORT2;
                end
                `CABLE_TEST_P3_IDX: begin
                    s.kind = port_phy_pkg::RK_TEST;
                    s.port = `PORT3;
                end
                `CABLE_TEST_P4_IDX: begin
                    s.kind = port_phy_pkg::RK_TEST;
                    s.port = `PORT4;
                end
                `CABLE_FAULT_LOW_P2_IDX: begin
                    s.kind = port_phy_pkg::RK_FAULT;
                    s.port = `PORT2;
                end
                `CABLE_FAULT_LOW_P3_IDX: begin
                    s.kind = port_phy_pkg::RK_FAULT;
                    s.port = `PORT3;
                end
                `CABLE_FAULT_LOW_P4_IDX: begin
                    s.kind = port_phy_pkg::RK_FAULT;
                    s.port = `PORT4;
                end
                default: begin
                    s.kind = port_phy_pkg::RK_NONE;
                end
            endcase
        end
        return s;
    endfunction

    // Selects the nine-bit fault count of ports 2 to 4.
    function automatic logic [8:0] fault_of(input logic [2:0] p,
                                            input logic [8:0] f2,
                                            input logic [8:0] f3,
                                            input logic [8:0] f4);
        logic [8:0] v;
        v = 9'h000;
        if (p == `PORT2) begin
            v = f2;
        end else if (p == `PORT3) begin
            v = f3;
        end else if (p == `PORT4) begin
            v = f4;
        end
        return v;
    endfunction

    strap_sync u_strap_sync (
        .aclk(aclk),
        .pin_in({port4_duplex_strap_pin, port3_duplex_strap_pin,
                 port4_neg_strap_pin, port3_neg_strap_pin}),
        .pin_sync(strap_sync_w)
    );

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready = !w_held_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wr_sel = decode(aw_addr_r);
    assign rd_sel = decode(s_axi_araddr);

    // Write address and data are caught separately, in either order.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_strb_r <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel.kind == port_phy_pkg::RK_NONE) ?
                       `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Straps reach the synchroniser output two edges into reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 5; i++) begin
                neg_ctrl_r[i] <= `NEG_CONTROL_RST;
            end
            neg_ctrl_r[`PORT3][`NEG_DIS_BIT] <= !strap_sync_w[0];
            neg_ctrl_r[`PORT4][`NEG_DIS_BIT] <= !strap_sync_w[1];
            neg_ctrl_r[`PORT3][`FDUPLEX_BIT] <= !strap_sync_w[2];
            neg_ctrl_r[`PORT4][`FDUPLEX_BIT] <= strap_sync_w[3];
        end else if (wr_fire && w_strb_r &&
                     wr_sel.kind == port_phy_pkg::RK_NEG) begin
            neg_ctrl_r[wr_sel.port] <= w_data_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_off_r <= 5'h00;
            tx_dis_r <= 5'h00;
        end else if (wr_fire && w_strb_r &&
                     wr_sel.kind == port_phy_pkg::RK_MISC) begin
            led_off_r[wr_sel.port] <= w_data_r[`LED_OFF_BIT];
            tx_dis_r[wr_sel.port] <= w_data_r[`TX_DIS_BIT];
        end
    end

    // The restart bit is a one-cycle pulse and never stores.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_r <= 5'h00;
        end else begin
            restart_r <= 5'h00;
            if (wr_fire && w_strb_r && w_data_r[`RESTART_BIT] &&
                wr_sel.kind == port_phy_pkg::RK_MISC) begin
                restart_r[wr_sel.port] <= 1'b1;
            end
        end
    end

    always_comb begin
        logic [8:0] f;
        f = fault_of(rd_sel.port, fault_count_p2, fault_count_p3,
                     fault_count_p4);
        rd_byte = 8'h00;
        unique case (rd_sel.kind)
            port_phy_pkg::RK_NEG: rd_byte = neg_ctrl_r[rd_sel.port];
            port_phy_pkg::RK_MISC: begin
                rd_byte[`LED_OFF_BIT] = led_off_r[rd_sel.port];
                rd_byte[`TX_DIS_BIT] = tx_dis_r[rd_sel.port];
            end
            // Each count unit stands for about 0.4 m of cable.
            port_phy_pkg::RK_TEST: rd_byte[0] = f[`FAULT_HI_BIT];
            port_phy_pkg::RK_FAULT: rd_byte = f[7:0];
            port_phy_pkg::RK_NONE: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= `RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= (rd_sel.kind == port_phy_pkg::RK_NONE) ?
                       `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign tx_disable = tx_dis_r;
    assign restart_neg = restart_r;

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : gen_port
            assign neg_enable[g] = !neg_ctrl_r[g][`NEG_DIS_BIT];
            assign adv_ability[5*g+4:5*g] = neg_ctrl_r[g][`ADV_MSB:0];
            port_ctrl u_port_ctrl (
                .aclk(aclk),
                .aresetn(aresetn),
                .neg_ctrl(neg_ctrl_r[g]),
                .led_off(led_off_r[g]),
                .neg_done(neg_done[g]),
                .neg_failed(neg_failed[g]),
                .res_speed_100(neg_res_speed_100[g]),
                .res_full_duplex(neg_res_full_duplex[g]),
                .led_normal(led_normal[3*g+2:3*g]),
                .link_speed_100(link_speed_100[g]),
                .link_full_duplex(link_full_duplex[g]),
                .port_led_pin(port_led_pin[3*g+2:3*g])
            );
        end
    endgenerate
endmodule

// File: testbench/port_phy_props.sv
// Concurrent checks on the port register bank ports.
`timescale 1ns/1ps
module port_phy_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [4:0] restart_neg,
    input wire logic [4:0] neg_enable,
    input wire logic [4:0] neg_done,
    input wire logic [4:0] neg_failed,
    input wire logic [4:0] neg_res_speed_100,
    input wire logic [4:0] neg_res_full_duplex,
    input wire logic [4:0] link_speed_100,
    input wire logic [4:0] link_full_duplex,
    input wire logic [14:0] led_normal,
    input wire logic [14:0] port_led_pin,
    input wire logic [24:0] adv_ability,
    input wire logic [4:0] tx_disable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    rdata_upper_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    restart_pulse_a: assert property (
        restart_neg != 5'h00 |=> restart_neg == 5'h00)
        else $error("restart not cleared");
    restart_cause_a: assert property (
        restart_neg != 5'h00 |-> $rose(s_axi_bvalid))
        else $error("restart without a write");
    neg_result_a: assert property (
        neg_enable[0] && neg_done[0] && !neg_failed[0] |=>
        link_speed_100[0] == $past(neg_res_speed_100[0]) &&
        link_full_duplex[0] == $past(neg_res_full_duplex[0]))
        else $error("resolved mode not applied");
    led_gate_a: assert property (
        port_led_pin[5:3] != 3'h7 |-> port_led_pin[5:3] == $past(led_normal[5:3]))
        else $error("led pins neither off nor normal");
    config_still_a: assert property (
        !$rose(s_axi_bvalid) |-> $stable(adv_ability) && $stable(tx_disable))
        else $error("config changed without a write");
endmodule
bind port_phy_control_regs port_phy_props props (.*);

// File: testbench/link_partner_model.sv
// Behavioural far-end PHY that answers each negotiation restart.
`timescale 1ns/1ps
module link_partner_model #(
    parameter int DELAY = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] restart_neg,
    input wire logic [24:0] adv_ability,
    input wire logic slow,
    input wire logic fail,
    output logic [4:0] neg_done,
    output logic [4:0] neg_failed,
    output logic [4:0] neg_res_speed_100,
    output logic [4:0] neg_res_full_duplex
);
    int cnt [5];
    logic [4:0] a;
    always @(posedge aclk) begin
        for (int i = 0; i < 5; i++) begin
            a = adv_ability[5 * i +: 5];
            if (!aresetn) begin
                cnt[i] <= 0;
                neg_done[i] <= 1'h0;
                neg_failed[i] <= 1'h0;
                neg_res_speed_100[i] <= 1'h0;
                neg_res_full_duplex[i] <= 1'h0;
            end else if (restart_neg[i]) begin
                neg_done[i] <= 1'h0;
                cnt[i] <= slow ? 4 * DELAY : DELAY;
            end else if (cnt[i] == 1) begin
                cnt[i] <= 0;
                neg_done[i] <= 1'h1;
                // A failed exchange still senses line speed, never duplex.
                neg_failed[i] <= fail || a[3:0] == 4'h0;
                neg_res_speed_100[i] <= fail || a[3] || a[2];
                neg_res_full_duplex[i] <= !fail && (a[3] || !a[2] && a[1]);
            end else if (cnt[i] > 1) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
    end
endmodule

// File: testbench/port_phy_control_regs_test.sv
// Self-checking bench for the port PHY control register bank.
`timescale 1ns/1ps
`include "port_phy_regs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module port_phy_control_regs_test;
    logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, fail = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic port3_neg_strap_pin = 1'h1, port4_neg_strap_pin = 1'h0;
    logic port3_duplex_strap_pin = 1'h0, port4_duplex_strap_pin = 1'h1;
    logic [8:0] fault_count_p2 = 9'h0, fault_count_p3 = 9'h0;
    logic [8:0] fault_count_p4 = 9'h0;
    logic [4:0] neg_done, neg_failed, neg_res_speed_100, neg_res_full_duplex;
    logic [14:0] led_normal = 15'h2A5A, port_led_pin;
    logic [4:0] neg_enable, tx_disable, restart_neg, link_speed_100;
    logic [4:0] link_full_duplex;
    logic [24:0] adv_ability;
    int mismatches = 0, comparisons = 0;
    always #50 aclk = ~aclk;
    port_phy_control_regs uut (.*);
    link_partner_model #(.DELAY(20)) peer (.*);
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Ready is offered with the request and dropped once the answer is taken.
    // Each call lets one edge pass first, so no strobe is set twice at once.
    task automatic wr(input logic [7:0] i, d, input logic [1:0] er);
        logic aw, w, dn;
        int n;
        n = 0;
        dn = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!dn && n < 100) begin
            @(negedge aclk);
            n++;
            aw = s_axi_awready;
            w = s_axi_wready;
            dn = s_axi_bvalid;
            if (dn) `CHK("bresp", er, s_axi_bresp)
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (dn) s_axi_bready <= 1'h0;
        end
        `CHK("wr done", 1'h1, dn)
    endtask
    task automatic rd(input logic [7:0] i, e, input logic [1:0] er);
        logic ar, dn;
        int n;
        n = 0;
        dn = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!dn && n < 100) begin
            @(negedge aclk);
            n++;
            ar = s_axi_arready;
            dn = s_axi_rvalid;
            if (dn) `CHK("rdata", {24'h0, e}, s_axi_rdata)
            if (dn) `CHK("rresp", er, s_axi_rresp)
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'h0;
            if (dn) s_axi_rready <= 1'h0;
        end
        `CHK("rd done", 1'h1, dn)
    endtask
    task automatic wait_neg(input int i);
        int n;
        n = 0;
        while (neg_done[i] !== 1'h1 && n < 500) begin
            @(negedge aclk);
            n++;
        end
        repeat (2) @(negedge aclk);
        `CHK("neg_done", 1'h1, neg_done[i])
        @(posedge aclk);
    endtask
    task automatic t_reset();
        logic [7:0] ne [5] = '{8'h5F, 8'h5F, 8'h7F, 8'hFF, 8'h5F};
        logic [7:0] o;
        for (int k = 0; k < 5; k++) begin
            o = 8'h10 * k[7:0];
            rd(`NEG_CONTROL_P1_IDX + o, ne[k], 2'h0);
            rd(`PORT_MISC_CONTROL_P1_IDX + o, 8'h00, 2'h0);
        end
        `CHK("neg_enable", 5'h17, neg_enable)
        `CHK("adv", {5{5'h1F}}, adv_ability)
        `CHK("leds", led_normal, port_led_pin)
        `CHK("tx_disable", 5'h00, tx_disable)
        `CHK("speed", 5'h1F, link_speed_100)
        `CHK("duplex", 5'h08, link_full_duplex)
        $display("reset defaults done");
    endtask
    task automatic t_fault();
        fault_count_p2 <= 9'h0FF;
        fault_count_p3 <= 9'h1A5;
        fault_count_p4 <= 9'h100;
        @(posedge aclk);
        rd(`CABLE_TEST_P2_IDX, 8'h00, 2'h0);
        rd(`CABLE_FAULT_LOW_P2_IDX, 8'hFF, 2'h0);
        rd(`CABLE_FAULT_LOW_P3_IDX, 8'hA5, 2'h0);
        rd(`CABLE_TEST_P4_IDX, 8'h01, 2'h0);
        rd(`CABLE_FAULT_LOW_P4_IDX, 8'h00, 2'h0);
        wr(`CABLE_TEST_P3_IDX, 8'hFE, 2'h0);
        rd(`CABLE_TEST_P3_IDX, 8'h01, 2'h0);
        wr(8'hF0, 8'h12, `RESP_SLVERR);
        rd(8'hF0, 8'h00, `RESP_SLVERR);
        $display("fault count done");
    endtask
    task automatic t_forced();
        wr(`NEG_CONTROL_P2_IDX, 8'h80, 2'h0);
        @(negedge aclk);
        `CHK("spd p2", 1'h0, link_speed_100[1])
        `CHK("dup p2", 1'h0, link_full_duplex[1])
        @(posedge aclk);
        wr(`NEG_CONTROL_P2_IDX, 8'hE0, 2'h0);
        @(negedge aclk);
        `CHK("spd p2", 1'h1, link_speed_100[1])
        `CHK("dup p2", 1'h1, link_full_duplex[1])
        @(posedge aclk);
        $display("forced mode done");
    endtask
    task automatic t_neg();
        wr(`NEG_CONTROL_P1_IDX, 8'h42, 2'h0);
        `CHK("adv p1", 5'h02, adv_ability[4:0])
        wr(`PORT_MISC_CONTROL_P1_IDX, 8'h20, 2'h0);
        wait_neg(0);
        `CHK("spd p1", 1'h0, link_speed_100[0])
        `CHK("dup p1", 1'h1, link_full_duplex[0])
        rd(`PORT_MISC_CONTROL_P1_IDX, 8'h00, 2'h0);
        fail <= 1'h1;
        slow <= 1'h1;
        wr(`NEG_CONTROL_P5_IDX, 8'h3F, 2'h0);
        wr(`PORT_MISC_CONTROL_P5_IDX, 8'h20, 2'h0);
        wait_neg(4);
        `CHK("spd p5", 1'h1, link_speed_100[4])
        `CHK("dup p5", 1'h1, link_full_duplex[4])
        $display("negotiation done");
    endtask
    task automatic t_misc();
        logic [14:0] el;
        led_normal <= 15'h15A5;
        wr(`PORT_MISC_CONTROL_P2_IDX, 8'hC0, 2'h0);
        el = {led_normal[14:6], 3'h7, led_normal[2:0]};
        @(negedge aclk);
        `CHK("leds", el, port_led_pin)
        `CHK("tx_disable", 5'h02, tx_disable)
        @(posedge aclk);
        rd(`PORT_MISC_CONTROL_P2_IDX, 8'hC0, 2'h0);
        wr(`PORT_MISC_CONTROL_P2_IDX, 8'h00, 2'h0);
        @(negedge aclk);
        `CHK("leds", led_normal, port_led_pin)
        `CHK("tx_disable", 5'h00, tx_disable)
        @(posedge aclk);
        $display("misc control done");
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_fault();
        t_forced();
        t_neg();
        t_misc();
        close_out();
    end
    initial begin
        #1000000;
        mismatches++;
        close_out();
    end
endmodule
